// file: dv/complex_output_stage_tb.sv
// self-checking testbench for the complex output stage
`timescale 1ns/1ps
module complex_output_stage_tb;
    logic        sys_clk, rst_n;                    // clock and reset
    logic [34:0] mul_re, mul_im;                    // product stimulus
    logic [1:0]  out_select;                        // bus selection
    logic        sum_or_dump, unsigned_fmt_n;       // accumulate and format pins
    logic        max_track_n;                       // peak tracking pin
    logic [4:0]  mult_round_width, acc_round_width; // rounding widths
    logic [3:0]  oe_n;                              // real low, real high, imag low, imag high
    logic [19:0] real_out_bus, imag_out_bus;        // registered bus data
    wire  [19:0] real_pins, imag_pins;              // resolved bus levels
    logic        r_lo, r_hi, i_lo, i_hi;            // driver enables from the stage
    logic [1:0]  growth_code;                       // growth report
    int          fails, total_checks;               // result counters
    localparam logic [34:0] P = 35'h2ABCDE123;      // first product pattern
    localparam logic [34:0] Q = 35'h154321FED;      // second product pattern

    cos_output_stage DUT (.sys_clk(sys_clk), .rst_n(rst_n), .mul_re(mul_re), .mul_im(mul_im),
        .out_select(out_select), .sum_or_dump(sum_or_dump), .unsigned_fmt_n(unsigned_fmt_n),
        .max_track_n(max_track_n), .mult_round_width(mult_round_width), .acc_round_width(acc_round_width),
        .real_low_oe_n(oe_n[0]), .real_high_oe_n(oe_n[1]), .imag_low_oe_n(oe_n[2]), .imag_high_oe_n(oe_n[3]),
        .real_out_bus(real_out_bus), .real_out_low_oe(r_lo), .real_out_high_oe(r_hi),
        .imag_out_bus(imag_out_bus), .imag_out_low_oe(i_lo), .imag_out_high_oe(i_hi),
        .growth_code(growth_code));
    cos_dac_model u_re (.bus_in(real_out_bus), .low_oe(r_lo), .high_oe(r_hi), .pins(real_pins));
    cos_dac_model u_im (.bus_in(imag_out_bus), .low_oe(i_lo), .high_oe(i_hi), .pins(imag_pins));

    // free-running 20 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    // verdict and end of run
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // one comparison, four-state exact
    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // round half up to width w, clamped to 9..20; carry out of bit 19 wraps
    function automatic logic [19:0] rnd(logic [19:0] v, logic [4:0] w);
        int d;
        d = 20 - (w < 9 ? 9 : (w > 20 ? 20 : int'(w)));
        if (d == 0) return v;
        return (v + (20'h00001 << (d - 1))) & ~((20'h00001 << d) - 20'h00001);
    endfunction

    // expected bus word; under continuous dump the accumulator equals product bits 34..15
    function automatic logic [19:0] sel_val(logic [34:0] p, logic [1:0] s, logic [4:0] mw, logic [4:0] aw);
        case (s)
            2'h0:    return rnd(p[34:15], mw);
            2'h1:    return rnd({p[34:31], 1'b0, p[14:0]}, mw);
            2'h2:    return rnd(p[34:15], aw);
            default: return 20'h00000;
        endcase
    endfunction

    // growth of one 4-bit field, sign bits compared downwards
    function automatic logic [1:0] grow(logic [3:0] f);
        return (f[3] != f[2]) ? 2'h3 : (f[2] != f[1]) ? 2'h2 : (f[1] != f[0]) ? 2'h1 : 2'h0;
    endfunction

    // apply pins off the edge, then wait out the synchroniser and pipeline latency
    task automatic drive(input logic [34:0] pr, pi, input logic [1:0] s, input logic sm, fm, tk,
                         input logic [4:0] mw, aw);
        @(posedge sys_clk);
        #5 {mul_re, mul_im, out_select, sum_or_dump, unsigned_fmt_n} = {pr, pi, s, sm, fm};
        {max_track_n, mult_round_width, acc_round_width} = {tk, mw, aw};
        repeat (8) @(posedge sys_clk);
        #5;
    endtask

    // both resolved buses against the expected words
    task automatic chk_bus(input logic [34:0] pr, pi, input string what);
        logic [19:0] inv;
        inv = unsigned_fmt_n ? 20'h00000 : 20'h80000;
        chk(real_pins, sel_val(pr, out_select, mult_round_width, acc_round_width) ^ inv, what);
        chk(imag_pins, sel_val(pi, out_select, mult_round_width, acc_round_width) ^ inv, what);
    endtask

    // every enable combination, changed mid-cycle
    task automatic test_oe;
        logic [19:0] er, ei;
        drive(P, Q, 2'h0, 1'b0, 1'b1, 1'b1, 5'h14, 5'h14);
        er = P[34:15];
        ei = Q[34:15];
        for (int i = 0; i < 16; i++) begin
            oe_n = i[3:0];
            #1;
            chk(real_pins, {oe_n[1] ? 4'hZ : er[19:16], oe_n[0] ? 16'hZZZZ : er[15:0]}, "real oe");
            chk(imag_pins, {oe_n[3] ? 4'hZ : ei[19:16], oe_n[2] ? 16'hZZZZ : ei[15:0]}, "imag oe");
        end
        oe_n = 4'h0;
        $display("test oe done");
    endtask

    // all four selections, unrounded
    task automatic test_select;
        for (int s = 0; s < 4; s++) begin
            drive(P, Q, s[1:0], 1'b0, 1'b1, 1'b1, 5'h14, 5'h14);
            chk_bus(P, Q, "select");
        end
        $display("test select done");
    endtask

    // independent widths, minimum width, and a width below range
    task automatic test_round;
        drive(P, Q, 2'h0, 1'b0, 1'b1, 1'b1, 5'h09, 5'h0E);
        chk_bus(P, Q, "round mult");
        drive(P, Q, 2'h2, 1'b0, 1'b1, 1'b1, 5'h09, 5'h0E);
        chk_bus(P, Q, "round acc");
        drive(Q, P, 2'h1, 1'b0, 1'b1, 1'b1, 5'h03, 5'h14);
        chk_bus(Q, P, "round clamp");
        $display("test round done");
    endtask

    // offset binary on product and accumulator selections
    task automatic test_format;
        drive(P, Q, 2'h0, 1'b0, 1'b0, 1'b1, 5'h14, 5'h14);
        chk_bus(P, Q, "format mult");
        drive(Q, P, 2'h2, 1'b0, 1'b0, 1'b1, 5'h0C, 5'h0B);
        chk_bus(Q, P, "format acc");
        $display("test format done");
    endtask

    // holding registers keep their word while accumulating, reload on dump
    // the product only moves once accumulate has passed the two-stage control sync
    task automatic test_hold;
        drive(P, Q, 2'h2, 1'b0, 1'b1, 1'b1, 5'h14, 5'h14);
        drive(P, Q, 2'h2, 1'b1, 1'b1, 1'b1, 5'h14, 5'h14);
        drive(Q, P, 2'h2, 1'b1, 1'b1, 1'b1, 5'h14, 5'h14);
        chk_bus(P, Q, "hold");
        drive(Q, P, 2'h2, 1'b0, 1'b1, 1'b1, 5'h14, 5'h14);
        chk_bus(Q, P, "dump");
        $display("test hold done");
    endtask

    // field growth, largest of four, bits outside fields ignored, peak tracking
    task automatic test_growth;
        drive(P, 35'h0, 2'h0, 1'b0, 1'b1, 1'b1, 5'h14, 5'h14);
        chk({18'h0, growth_code}, {18'h0, grow(P[33:30])}, "growth real");
        drive(35'h0, 35'h040000000, 2'h0, 1'b0, 1'b1, 1'b1, 5'h14, 5'h14);
        chk({18'h0, growth_code}, 20'h00001, "growth imag");
        drive(35'h420000000, 35'h0, 2'h0, 1'b0, 1'b1, 1'b1, 5'h14, 5'h14);
        chk({18'h0, growth_code}, 20'h00000, "growth outside");
        drive(35'h0C0000000, 35'h0, 2'h0, 1'b0, 1'b1, 1'b0, 5'h14, 5'h14);
        chk({18'h0, growth_code}, 20'h00002, "peak load");
        drive(35'h0, 35'h0, 2'h0, 1'b0, 1'b1, 1'b0, 5'h14, 5'h14);
        chk({18'h0, growth_code}, 20'h00002, "peak kept");
        drive(35'h0, 35'h0, 2'h0, 1'b0, 1'b1, 1'b1, 5'h14, 5'h14);
        chk({18'h0, growth_code}, 20'h00000, "peak off");
        $display("test growth done");
    endtask

    // bounded run length; expiry is a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        wrap_up();
    end

    // main sequence: reset held for 16 cycles, then each scenario
    initial begin
        fails = 0;
        total_checks = 0;
        rst_n = 1'b0;
        {mul_re, mul_im, out_select, sum_or_dump, unsigned_fmt_n} = {35'h0, 35'h0, 2'h0, 1'b1, 1'b1};
        {max_track_n, mult_round_width, acc_round_width, oe_n} = {1'b1, 5'h14, 5'h14, 4'h0};
        repeat (16) @(posedge sys_clk);
        #5 rst_n = 1'b1;
        test_oe();
        test_select();
        test_round();
        test_format();
        test_hold();
        test_growth();
        wrap_up();
    end
endmodule // complex_output_stage_tb

// file: dv/cos_dac_model.sv
// downstream converter model that resolves the three-state result buses
`timescale 1ns/1ps
module cos_dac_model (
    input  wire logic [19:0] bus_in,  // registered data from the stage
    input  wire logic        low_oe,  // high while bits 0..15 are driven
    input  wire logic        high_oe, // high while bits 16..19 are driven
    output wire logic [19:0] pins     // level the converter sees
);
    // an undriven group floats, so a released bus can never pass for data
    assign pins[15:0]  = low_oe ? bus_in[15:0] : 16'hZZZZ;
    assign pins[19:16] = high_oe ? bus_in[19:16] : 4'hZ;
endmodule // cos_dac_model

// file: hdl/cos_growth_det.sv
// block floating point growth detector with peak tracking
`timescale 1ns/1ps
module cos_growth_det (
    input  wire logic                                 sys_clk,
    input  wire logic                                 rst_n,
    input  wire logic [cos_pkg::NUM_DET*cos_pkg::DET_W-1:0] fields,      // four 4-bit growth fields
    input  wire logic                                 max_track_s_n, // synchronised, low tracks peak
    output logic      [1:0]                           growth_code
);
    logic [1:0] code_w [cos_pkg::NUM_DET];   // growth per holding register
    logic [1:0] cur_max;                     // largest of the four right now
    logic [1:0] nxt_growth;
    logic [1:0] growth_ff;

    // per register: growth is the highest bit that leaves the sign extension
    genvar gi;
    generate
        for (gi = 0; gi < cos_pkg::NUM_DET; gi++) begin : g_det
            wire [3:0] f = fields[gi*cos_pkg::DET_W +: cos_pkg::DET_W];
            assign code_w[gi] = (f[3] != f[2]) ? 2'h3 :
                                (f[2] != f[1]) ? 2'h2 :
                                (f[1] != f[0]) ? 2'h1 : 2'h0;
        end
    endgenerate

    // pick the largest and, while tracking, never fall below the held peak
    always_comb begin
        cur_max = 2'h0;
        for (int i = 0; i < cos_pkg::NUM_DET; i++) begin
            if (code_w[i] > cur_max) begin
                cur_max = code_w[i];
            end
        end
        nxt_growth = cur_max;
        if (!max_track_s_n && growth_ff > cur_max) begin
            nxt_growth = growth_ff;
        end
    end

    // register the code so the pin comes from a flip-flop
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            growth_ff <= cos_pkg::GROWTH_RST;
        end else begin
            growth_ff <= nxt_growth;
        end
    end

    assign growth_code = growth_ff;

    AST_GROWTH_IS_MAX: assert property (@(posedge sys_clk) disable iff (!rst_n)
        max_track_s_n |=> growth_ff == $past(cur_max))
        else $error("growth code is not the largest current growth");
    AST_PEAK_HOLDS: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !max_track_s_n |=> growth_ff >= $past(growth_ff) && growth_ff >= $past(cur_max))
        else $error("peak growth dropped while tracking");
    AST_TOP_BIT_GROWTH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (max_track_s_n && fields[3] != fields[2]) |=> growth_ff == 2'h3)
        else $error("three bits of growth not coded as 11");
    COV_PEAK: cover property (@(posedge sys_clk) disable iff (!rst_n)
        !max_track_s_n && growth_ff == 2'h3 && cur_max == 2'h0);
endmodule // cos_growth_det

// file: hdl/cos_output_stage.sv
// complex output stage: accumulate/dump, holding registers, select, rounding, format, three-state buses
// Functional notes
// - real bus is 20 bits, bit 19 msb
// - imaginary bus is 20 bits, bit 19 msb
// - real bus low/high groups have own enables
// - imaginary bits 0-15 driven while low enable low
// - imaginary bits 16-19 driven while high enable low
// - select picks multiplier or accumulator bits
// - growth code is plain binary 0 to 3
// - inspect accumulator 15-18, product 30-33
// - report largest growth of four registers
// - max track low reports peak growth
// - round results to 9..20 bits
// - multiplier and accumulator widths set independently
// - format low inverts bit 19 on both buses
// - sum high accumulates and holds; low dumps
`timescale 1ns/1ps
module cos_output_stage (
    input  wire logic                        sys_clk,
    input  wire logic                        rst_n,
    input  wire logic [cos_pkg::PROD_W-1:0]  mul_re,           // real product, same clock domain
    input  wire logic [cos_pkg::PROD_W-1:0]  mul_im,           // imaginary product
    input  wire logic [1:0]                  out_select,       // pin
    input  wire logic                        sum_or_dump,      // pin, high accumulates
    input  wire logic                        unsigned_fmt_n,   // pin, low gives offset binary
    input  wire logic                        max_track_n,      // pin, low tracks peak growth
    input  wire logic [cos_pkg::RW_W-1:0]    mult_round_width, // pin, 9..20
    input  wire logic [cos_pkg::RW_W-1:0]    acc_round_width,  // pin, 9..20
    input  wire logic                        real_low_oe_n,
    input  wire logic                        real_high_oe_n,
    input  wire logic                        imag_low_oe_n,
    input  wire logic                        imag_high_oe_n,
    output logic      [cos_pkg::OUT_W-1:0]   real_out_bus,
    output logic                             real_out_low_oe,
    output logic                             real_out_high_oe,
    output logic      [cos_pkg::OUT_W-1:0]   imag_out_bus,
    output logic                             imag_out_low_oe,
    output logic                             imag_out_high_oe,
    output logic      [1:0]                  growth_code
);
    // control pins pass two flip-flops; the second stage is the clock registration
    logic [cos_pkg::CTL_W-1:0] ctl_raw;
    logic [cos_pkg::CTL_W-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic [1:0]                sel_s;
    logic                      sum_s, fmt_s_n, track_s_n;
    logic [cos_pkg::RW_W-1:0]  mw_s, aw_s;

    // accumulators and holding registers
    logic [cos_pkg::ACC_W-1:0]  acc_re_ff, acc_im_ff, nxt_acc_re, nxt_acc_im;
    logic [cos_pkg::ACC_W-1:0]  ahold_re_ff, ahold_im_ff, nxt_ahold_re, nxt_ahold_im;
    logic [cos_pkg::PROD_W-1:0] mhold_re_ff, mhold_im_ff, nxt_mhold_re, nxt_mhold_im;

    // output word registers
    logic [cos_pkg::OUT_W-1:0] real_ff, imag_ff, nxt_real, nxt_imag;

    assign ctl_raw = {out_select, sum_or_dump, unsigned_fmt_n, max_track_n, mult_round_width, acc_round_width};
    assign {sel_s, sum_s, fmt_s_n, track_s_n, mw_s, aw_s} = sync2_ff;

    // synchroniser next state: stage one only feeds stage two
    always_comb begin
        nxt_sync1 = ctl_raw;
        nxt_sync2 = sync1_ff;
    end

    // synchroniser registers; reset leaves accumulate on and tracking off
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 15'h1E94;
            sync2_ff <= 15'h1E94;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    // rounding: add half an lsb of the kept width, clear the dropped bits
    // a carry out of bit 19 wraps; callers near full scale must leave headroom
    function automatic logic [19:0] cos_round(input logic [19:0] w, input logic [4:0] width);
        logic [4:0]  wc;
        logic [4:0]  drop;
        logic [19:0] half;
        logic [19:0] mask;
        wc   = (width < cos_pkg::RND_MIN) ? cos_pkg::RND_MIN :
               (width > cos_pkg::RND_MAX) ? cos_pkg::RND_MAX : width;
        drop = cos_pkg::RND_MAX - wc;
        half = (drop == 5'h00) ? 20'h00000 : (20'h00001 << (drop - 5'h01));
        mask = ~((20'h00001 << drop) - 20'h00001);
        return (w + half) & mask;
    endfunction

    // map one channel to its bus word, then round and format it
    function automatic logic [19:0] cos_word(input logic [34:0] m, input logic [19:0] a,
                                             input logic [1:0] sel, input logic [4:0] mw,
                                             input logic [4:0] aw, input logic fmt_n);
        logic [19:0] w;
        w = 20'h00000;
        case (sel)
            cos_pkg::SEL_MUL_HI: w = cos_round(m[34:15], mw);
            cos_pkg::SEL_MUL_LO: w = cos_round({m[34:31], 1'b0, m[14:0]}, mw);
            cos_pkg::SEL_ACC:    w = cos_round(a, aw);
            default:             w = 20'h00000;            // reserved code gives zeros; offset binary still inverts bit 19
        endcase
        if (!fmt_n) begin
            w[cos_pkg::MSB_POS] = ~w[cos_pkg::MSB_POS];
        end
        return w;
    endfunction

    // accumulate/dump: feedback zeroed on dump, holding registers load on dump only
    always_comb begin
        nxt_acc_re   = (sum_s ? acc_re_ff : 20'h00000) + mul_re[34:15];
        nxt_acc_im   = (sum_s ? acc_im_ff : 20'h00000) + mul_im[34:15];
        nxt_ahold_re = ahold_re_ff;
        nxt_ahold_im = ahold_im_ff;
        nxt_mhold_re = mhold_re_ff;
        nxt_mhold_im = mhold_im_ff;
        if (!sum_s) begin
            nxt_ahold_re = nxt_acc_re;
            nxt_ahold_im = nxt_acc_im;
            nxt_mhold_re = mul_re;
            nxt_mhold_im = mul_im;
        end
        nxt_real = cos_word(mhold_re_ff, ahold_re_ff, sel_s, mw_s, aw_s, fmt_s_n);
        nxt_imag = cos_word(mhold_im_ff, ahold_im_ff, sel_s, mw_s, aw_s, fmt_s_n);
    end

    // datapath registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_re_ff   <= 20'h00000;
            acc_im_ff   <= 20'h00000;
            ahold_re_ff <= 20'h00000;
            ahold_im_ff <= 20'h00000;
            mhold_re_ff <= 35'h000000000;
            mhold_im_ff <= 35'h000000000;
            real_ff     <= cos_pkg::OUT_RST;
            imag_ff     <= cos_pkg::OUT_RST;
        end else begin
            acc_re_ff   <= nxt_acc_re;
            acc_im_ff   <= nxt_acc_im;
            ahold_re_ff <= nxt_ahold_re;
            ahold_im_ff <= nxt_ahold_im;
            mhold_re_ff <= nxt_mhold_re;
            mhold_im_ff <= nxt_mhold_im;
            real_ff     <= nxt_real;
            imag_ff     <= nxt_imag;
        end
    end

    assign real_out_bus = real_ff;
    assign imag_out_bus = imag_ff;

    // enables go straight to the drivers so a bus releases without waiting for a clock
    assign real_out_low_oe  = !real_low_oe_n;
    assign real_out_high_oe = !real_high_oe_n;
    assign imag_out_low_oe  = !imag_low_oe_n;
    assign imag_out_high_oe = !imag_high_oe_n;

    // growth fields: accumulator bits 15..18 and product bits 30..33
    cos_growth_det u_growth (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .fields        ({mhold_im_ff[33:30], mhold_re_ff[33:30],
                         ahold_im_ff[18:15], ahold_re_ff[18:15]}),
        .max_track_s_n (track_s_n),
        .growth_code   (growth_code)
    );

    AST_OE_REAL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (real_out_low_oe != real_low_oe_n) && (real_out_high_oe != real_high_oe_n))
        else $error("real bus enables do not follow their pins");
    AST_OE_IMAG_LOW: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $fell(imag_low_oe_n) |-> imag_out_low_oe)
        else $error("imaginary low group not driven at once");
    AST_OE_IMAG_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(imag_high_oe_n) |-> !imag_out_high_oe)
        else $error("imaginary high group not released at once");
    AST_SEL_MUL: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_s == cos_pkg::SEL_MUL_HI && mw_s == cos_pkg::RND_MAX && fmt_s_n)
        |=> real_out_bus == $past(mhold_re_ff[34:15]) && imag_out_bus == $past(mhold_im_ff[34:15]))
        else $error("multiplier bits not on the buses");
    AST_ROUND_ACC: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_s == cos_pkg::SEL_ACC && aw_s == cos_pkg::RND_MIN) |=> real_out_bus[10:0] == 11'h000)
        else $error("accumulator not rounded to nine bits");
    AST_ROUND_INDEP: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_s == cos_pkg::SEL_ACC && aw_s == cos_pkg::RND_MAX && fmt_s_n)
        |=> imag_out_bus == $past(ahold_im_ff))
        else $error("multiplier width leaked into accumulator output");
    AST_OFFSET_BIN: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (!fmt_s_n && sel_s == cos_pkg::SEL_ACC && aw_s == cos_pkg::RND_MAX)
        |=> real_out_bus[19] == !$past(ahold_re_ff[19]) && imag_out_bus[19] == !$past(ahold_im_ff[19]))
        else $error("msb not inverted for offset binary");
    AST_HOLD_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
        sum_s |=> $stable(ahold_re_ff) && $stable(mhold_im_ff))
        else $error("holding register moved while accumulating");
    AST_DUMP_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !sum_s |=> acc_re_ff == $past(mul_re[34:15]) && ahold_re_ff == acc_re_ff)
        else $error("dump did not zero feedback and load holding register");
    AST_BUS_MSB: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (sel_s == cos_pkg::SEL_MUL_LO && mw_s == cos_pkg::RND_MAX && fmt_s_n)
        |=> real_out_bus[19] == $past(mhold_re_ff[34]) && imag_out_bus[15] == 1'b0)
        else $error("msb or zero fill misplaced");
    COV_DUMP: cover property (@(posedge sys_clk) disable iff (!rst_n) sum_s ##1 !sum_s);
    COV_ACC_SEL: cover property (@(posedge sys_clk) disable iff (!rst_n) sel_s == cos_pkg::SEL_ACC && !fmt_s_n);
    COV_OE_OFF: cover property (@(posedge sys_clk) disable iff (!rst_n) !real_out_low_oe && imag_out_high_oe);
endmodule // cos_output_stage

// file: inc/cos_pkg.sv
// constants shared by the complex output stage and its growth detector
package cos_pkg;
    localparam int          OUT_W       = 20;      // width of each result bus
    localparam int          PROD_W      = 35;      // multiplier product width, bits 0..34
    localparam int          ACC_W       = 20;      // accumulator width, bits 0..19
    localparam int          RW_W        = 5;       // width of a rounding-width control
    localparam int          MSB_POS     = 19;      // bus bit carrying the msb
    localparam int          LOW_W       = 16;      // bits 0..15 of a bus form the low group
    localparam int          PROD_HI_LSB = 31;      // product bits 31..34 feed bus bits 16..19
    localparam int          PROD_MID    = 15;      // product bits 15..30 feed bus bits 0..15
    localparam int          ACC_DET_LSB = 15;      // accumulator growth field is bits 15..18
    localparam int          MUL_DET_LSB = 30;      // product growth field is bits 30..33
    localparam int          DET_W       = 4;       // width of one growth field
    localparam int          NUM_DET     = 4;       // holding registers inspected
    localparam logic [1:0]  SEL_MUL_HI  = 2'h0;    // product bits 15..34
    localparam logic [1:0]  SEL_MUL_LO  = 2'h1;    // product bits 31..34, a zero, bits 0..14
    localparam logic [1:0]  SEL_ACC     = 2'h2;    // accumulator bits 0..19
    localparam logic [4:0]  RND_MIN     = 5'h09;   // narrowest rounded width
    localparam logic [4:0]  RND_MAX     = 5'h14;   // widest width, no rounding
    localparam logic [19:0] OUT_RST     = 20'h00000;
    localparam logic [1:0]  GROWTH_RST  = 2'h0;
    localparam int          CTL_W       = 15;      // synchronised control bundle width
endpackage
